// *** pkg/usc_defs.svh ***
`ifndef USC_DEFS_SVH
`define USC_DEFS_SVH
// register indices; the byte address on the bus is four times the index
`define USC_IDX_FLAGS_TWO   8'h10
`define USC_IDX_RX_CTRL_ONE 8'h13
`define USC_IDX_TX_CTRL_ONE 8'h15
`define USC_IDX_FLAGS_ONE   8'h16
`define USC_IDX_TX_DATA_ONE 8'h18
`define USC_IDX_RX_DATA_ONE 8'h19
`define USC_IDX_IRQ_ENABLE  8'h1a
`define USC_IDX_RX_CTRL_TWO 8'h33
`define USC_IDX_TX_CTRL_TWO 8'h35
`define USC_IDX_TX_DATA_TWO 8'h38
`define USC_IDX_RX_DATA_TWO 8'h39
// transmit control and status fields
`define USC_TX_CLK_SRC  7
`define USC_TX_NINE     6
`define USC_TX_EN       5
`define USC_TX_SYNC     4
`define USC_TX_SR_EMPTY 1
`define USC_TX_NINTH    0
// receive control and status fields
`define USC_RX_PORT_EN  7
`define USC_RX_NINE     6
`define USC_RX_SINGLE   5
`define USC_RX_CONT     4
`define USC_RX_FRAME    2
`define USC_RX_OVERRUN  1
`define USC_RX_NINTH    0
// flag register fields, same place for both ports
`define USC_FLAG_TX     1
`define USC_FLAG_RX     0
// interrupt enable fields: port p receive at 2p, transmit at 2p+1
`define USC_IE_RX_ONE   0
`define USC_IE_TX_ONE   1
`define USC_IE_RX_TWO   2
`define USC_IE_TX_TWO   3
// reset values
`define USC_CTRL_RST    1'b0
`define USC_IRQ_EN_RST  4'h0
`define USC_BYTE_RST    8'h00
`endif

// *** pkg/usc_pkg.sv ***
package usc_pkg;
   // controls and transmit word handed to one port's shift datapath
   typedef struct packed {
      logic       pin_enable;  // pins belong to the serial port
      logic       sync_mode;   // synchronous operation
      logic       clk_master;  // clock from the baud rate generator
      logic       nine_tx;     // nine-bit characters out
      logic       nine_rx;     // nine-bit characters in
      logic       tx_run;      // transmitter enabled
      logic       rx_run;      // receiver enabled
      logic       tx_load;     // one-cycle pulse: tx_word enters shift register
      logic [8:0] tx_word;     // character, ninth bit on top
   } usc_link_out_t;
   // events from one port's shift datapath
   typedef struct packed {
      logic       tsr_done;    // one-cycle pulse: last bit shifted out
      logic       rx_valid;    // one-cycle pulse: a character arrived
      logic [8:0] rx_word;     // received character, ninth bit on top
      logic       rx_framing_error;     // that character had a bad stop bit
   } usc_link_in_t;
   // transmit shift register occupancy
   typedef enum logic [1:0] {
      USC_TSR_EMPTY = 2'b01,
      USC_TSR_BUSY  = 2'b10
   } usc_tsr_state_t;
endpackage

// *** design/usc_rx_status.sv ***
`timescale 1ns/1ps
`include "usc_defs.svh"
// receive buffer and its error status for one port
module usc_rx_status (
   // clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // receive events
   input  wire logic       rx_take,     // character offered while receiving
   input  wire logic [8:0] rx_word,
   input  wire logic       rx_framing_error,
   input  wire logic       nine_rx,
   // software side
   input  wire logic       buf_read,    // software reads the data buffer
   input  wire logic       cont_clear,  // software clears continuous receive
   // status
   output logic [7:0]      data_reg,
   output logic            ninth_reg,
   output logic            framing_error_reg,
   output logic            overrun_error_reg,
   output logic            full_reg
);
   wire accept;   // character lands in the buffer
   wire overrun;  // character lost
   // a read in the same cycle frees room, so a back-to-back char is kept
   assign accept  = rx_take & ~overrun_error_reg & (~full_reg | buf_read);
   assign overrun = rx_take & ~accept;

   ////////////////////////////////////////////////////////////////////////
   // buffer, ninth bit and errors
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         data_reg  <= `USC_BYTE_RST;
         ninth_reg <= `USC_CTRL_RST;
         framing_error_reg  <= `USC_CTRL_RST;
         overrun_error_reg  <= `USC_CTRL_RST;
         full_reg  <= `USC_CTRL_RST;
      end else begin
         if (accept) begin
            data_reg  <= rx_word[7:0];
            ninth_reg <= nine_rx & rx_word[8];  // [R15] [R8]
         end
         // frame status follows the buffer: set on arrival, refreshed by a read
         if (accept) begin
            framing_error_reg <= rx_framing_error;                 // [R13]
         end else if (buf_read) begin
            framing_error_reg <= 1'b0;                    // [R13]
         end
         // set wins over the clear
         if (overrun) begin
            overrun_error_reg <= 1'b1;                    // [R14]
         end else if (cont_clear) begin
            overrun_error_reg <= 1'b0;                    // [R14]
         end
         if (accept) begin
            full_reg <= 1'b1;
         end else if (buf_read) begin
            full_reg <= 1'b0;
         end
      end
   end
endmodule

// *** design/usc_top.sv ***
// Function
// R1 - sync clock: master internal, slave external pin
// R2 - nine-bit transmit select picks character width
// R3 - transmit enable; receive enables override in sync
// R4 - mode bit selects synchronous or asynchronous
// R5 - read-only shift-register-empty bit, resets one
// R6 - ninth transmit bit sent as ninth bit
// R7 - port enable gives pins to serial port
// R8 - nine-bit receive select picks character width
// R9 - single receive takes one byte, self-clears
// R10 - single receive ignored in sync slave
// R11 - async receives while continuous enable set
// R12 - sync continuous receive overrides single receive
// R13 - framing error set, refreshed by buffer read
// R14 - overrun set; cleared only via continuous clear
// R15 - received ninth bit stored for software
// R16 - port one transmit flag shows buffer empty
// R17 - port one receive flag shows buffer full
// R18 - port two flags in second flag register
// R19 - unimplemented control bits read zero
// R20 - interrupts gated by their enable bits
// R21 - writes to hardware flags are ignored
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`include "usc_defs.svh"
module usc_top (
   // clock and reset
   input  wire logic                           pclk,
   input  wire logic                           presetn,
   // apb slave
   input  wire logic                           psel,
   input  wire logic                           penable,
   input  wire logic                           pwrite,
   input  wire logic [11:0]                    paddr,
   input  wire logic [31:0]                    pwdata,
   output logic      [31:0]                    prdata,
   output logic                                pready,
   output logic                                pslverr,
   // shift datapaths, index 0 is port one
   output usc_pkg::usc_link_out_t [1:0]        link_out,
   input  wire usc_pkg::usc_link_in_t [1:0]    link_in,
   // gated interrupt requests, bit 0 is port one
   output logic      [1:0]                     tx_irq,
   output logic      [1:0]                     rx_irq
);
   ////////////////////////////////////////////////////////////////////////
   // bus phases
   wire       setup;      // first cycle of a transfer
   wire       access;     // last cycle, write takes effect here
   wire [9:0] word_idx;   // word index of the address
   wire       align_ok;   // byte address is word aligned
   assign setup    = psel & ~penable;
   assign access   = psel & penable & pready;
   assign word_idx = paddr[11:2];
   assign align_ok = (paddr[1:0] == 2'h0);

   // shared address hits
   wire hit_flags_one;
   wire hit_flags_two;
   wire hit_irq_en;
   assign hit_flags_one = align_ok & (word_idx == {2'h0, `USC_IDX_FLAGS_ONE});
   assign hit_flags_two = align_ok & (word_idx == {2'h0, `USC_IDX_FLAGS_TWO});
   assign hit_irq_en    = align_ok & (word_idx == {2'h0, `USC_IDX_IRQ_ENABLE});

   // per-port hits and read words
   logic [1:0] hit_tx_ctrl;
   logic [1:0] hit_rx_ctrl;
   logic [1:0] hit_tx_data;
   logic [1:0] hit_rx_data;
   logic [7:0] rd_tx_ctrl [2];
   logic [7:0] rd_rx_ctrl [2];
   logic [7:0] rd_rx_data [2];
   logic [1:0] flag_tx;      // transmit buffer empty
   logic [1:0] flag_rx;      // receive buffer full

   // interrupt enables
   logic [3:0] irq_en_reg;
   logic [3:0] irq_en_next;
   wire        wr_irq_en;
   assign wr_irq_en   = access & pwrite & hit_irq_en;
   assign irq_en_next = wr_irq_en ? pwdata[3:0] : irq_en_reg;

   ////////////////////////////////////////////////////////////////////////
   // one control and status slice per port
   genvar p;
   generate
      for (p = 0; p < 2; p++) begin : g_port
         localparam logic [7:0] TXC = (p == 0) ? `USC_IDX_TX_CTRL_ONE : `USC_IDX_TX_CTRL_TWO;
         localparam logic [7:0] RXC = (p == 0) ? `USC_IDX_RX_CTRL_ONE : `USC_IDX_RX_CTRL_TWO;
         localparam logic [7:0] TXD = (p == 0) ? `USC_IDX_TX_DATA_ONE : `USC_IDX_TX_DATA_TWO;
         localparam logic [7:0] RXD = (p == 0) ? `USC_IDX_RX_DATA_ONE : `USC_IDX_RX_DATA_TWO;

         // control bits
         logic clk_src_reg;     // clock_source_select
         logic nine_tx_reg;     // nine_bit_transmit_select
         logic tx_en_reg;       // transmit_enable
         logic sync_reg;        // mode select
         logic tx_ninth_reg;    // transmit_ninth_bit
         logic serial_port_enable_reg;        // serial_port_enable
         logic nine_rx_reg;     // nine_bit_receive_select
         logic single_reg;      // single_receive_enable
         logic cont_reg;        // continuous_receive_enable
         logic single_next;
         // transmit buffer and shift register
         logic [7:0] tx_buf_reg;
         logic       tx_full_reg;
         logic       tx_full_next;
         usc_pkg::usc_tsr_state_t tsr_reg;
         usc_pkg::usc_tsr_state_t tsr_next;
         usc_pkg::usc_link_out_t  lo_next;
         // receive status from the slice
         logic [7:0] rx_data;
         logic       rx_ninth;
         logic       rx_framing_error_st;
         logic       rx_overrun_error;
         logic       rx_full;

         // decode
         assign hit_tx_ctrl[p] = align_ok & (word_idx == {2'h0, TXC});
         assign hit_rx_ctrl[p] = align_ok & (word_idx == {2'h0, RXC});
         assign hit_tx_data[p] = align_ok & (word_idx == {2'h0, TXD});
         assign hit_rx_data[p] = align_ok & (word_idx == {2'h0, RXD});

         wire wr_txc;      // control write, taken at the access edge
         wire wr_rxc;
         wire wr_txd;
         wire rd_rxd;      // buffer read, consumed when the data is sampled
         assign wr_txc = access & pwrite & hit_tx_ctrl[p];
         assign wr_rxc = access & pwrite & hit_rx_ctrl[p];
         assign wr_txd = access & pwrite & hit_tx_data[p];
         assign rd_rxd = setup & ~pwrite & hit_rx_data[p];

         // operating mode
         wire master;      // sync master drives the clock
         wire rx_active;   // receiver running
         wire tx_active;   // transmitter running
         wire tsr_empty;
         wire tsr_take;    // buffer moves into shift register
         wire rx_take;     // arriving character is accepted for checking
         wire single_done; // one-byte reception finished
         wire cont_clear;  // software drops continuous receive
         assign master    = sync_reg & clk_src_reg;                       // [R1] [R4]
         // slave reception ignores single receive; continuous overrides it
         assign rx_active = serial_port_enable_reg & (cont_reg | (sync_reg & master & single_reg)); // [R9] [R10] [R11] [R12]
         assign tx_active = serial_port_enable_reg & tx_en_reg & ~(sync_reg & (single_reg | cont_reg)); // [R3] [R7]
         assign tsr_empty = (tsr_reg == usc_pkg::USC_TSR_EMPTY);
         assign tsr_take  = tx_active & tx_full_reg & tsr_empty;
         assign rx_take   = rx_active & link_in[p].rx_valid;
         assign single_done = rx_take & sync_reg & single_reg & ~cont_reg; // [R9]
         assign cont_clear  = wr_rxc & ~pwdata[`USC_RX_CONT];              // [R14]

         // software write of single receive wins over the self-clear
         assign single_next = wr_rxc ? pwdata[`USC_RX_SINGLE] :
                              (single_done ? 1'b0 : single_reg);            // [R9]
         // a write while full replaces the waiting character
         assign tx_full_next = wr_txd | (tx_full_reg & ~tsr_take);

         // shift register occupancy
         always_comb begin
            tsr_next = tsr_reg;
            case (tsr_reg)
               usc_pkg::USC_TSR_EMPTY: begin
                  if (tsr_take) begin
                     tsr_next = usc_pkg::USC_TSR_BUSY;
                  end
               end
               usc_pkg::USC_TSR_BUSY: begin
                  // disabling the port abandons the character
                  if (link_in[p].tsr_done | ~serial_port_enable_reg) begin
                     tsr_next = usc_pkg::USC_TSR_EMPTY;
                  end
               end
               default: begin
                  tsr_next = usc_pkg::USC_TSR_EMPTY;
               end
            endcase
         end

         // datapath controls, registered so the ports come from flops
         always_comb begin
            lo_next            = link_out[p];
            lo_next.pin_enable = serial_port_enable_reg;    // [R7]
            lo_next.sync_mode  = sync_reg;    // [R4]
            lo_next.clk_master = master;      // [R1]
            lo_next.nine_tx    = nine_tx_reg; // [R2]
            lo_next.nine_rx    = nine_rx_reg; // [R8]
            lo_next.tx_run     = tx_active;   // [R3]
            lo_next.rx_run     = rx_active;   // [R11] [R12]
            lo_next.tx_load    = tsr_take;
            if (tsr_take) begin
               lo_next.tx_word = {nine_tx_reg & tx_ninth_reg, tx_buf_reg};  // [R2] [R6]
            end
         end

         // control registers
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               clk_src_reg  <= `USC_CTRL_RST;
               nine_tx_reg  <= `USC_CTRL_RST;
               tx_en_reg    <= `USC_CTRL_RST;
               sync_reg     <= `USC_CTRL_RST;
               tx_ninth_reg <= `USC_CTRL_RST;
            end else if (wr_txc) begin
               // shift-register-empty is read only
               clk_src_reg  <= pwdata[`USC_TX_CLK_SRC];
               nine_tx_reg  <= pwdata[`USC_TX_NINE];
               tx_en_reg    <= pwdata[`USC_TX_EN];
               sync_reg     <= pwdata[`USC_TX_SYNC];
               tx_ninth_reg <= pwdata[`USC_TX_NINTH];
            end
         end

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               serial_port_enable_reg    <= `USC_CTRL_RST;
               nine_rx_reg <= `USC_CTRL_RST;
               cont_reg    <= `USC_CTRL_RST;
            end else if (wr_rxc) begin
               // error bits and received ninth bit are read only
               serial_port_enable_reg    <= pwdata[`USC_RX_PORT_EN];
               nine_rx_reg <= pwdata[`USC_RX_NINE];
               cont_reg    <= pwdata[`USC_RX_CONT];
            end
         end

         // transmit path and datapath port registers
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               single_reg  <= `USC_CTRL_RST;
               tx_buf_reg  <= `USC_BYTE_RST;
               tx_full_reg <= `USC_CTRL_RST;
               tsr_reg     <= usc_pkg::USC_TSR_EMPTY;                      // [R5]
               link_out[p] <= '0;
            end else begin
               single_reg  <= single_next;
               tx_full_reg <= tx_full_next;
               tsr_reg     <= tsr_next;
               link_out[p] <= lo_next;
               if (wr_txd) begin
                  tx_buf_reg <= pwdata[7:0];
               end
            end
         end

         // receive buffer and error status
         usc_rx_status u_rx (
            .pclk       (pclk),
            .presetn    (presetn),
            .rx_take    (rx_take),
            .rx_word    (link_in[p].rx_word),
            .rx_framing_error    (link_in[p].rx_framing_error),
            .nine_rx    (nine_rx_reg),
            .buf_read   (rd_rxd),
            .cont_clear (cont_clear),
            .data_reg   (rx_data),
            .ninth_reg  (rx_ninth),
            .framing_error_reg   (rx_framing_error_st),
            .overrun_error_reg   (rx_overrun_error),
            .full_reg   (rx_full)
         );

         // hardware-owned flags, no write path reaches them
         assign flag_tx[p] = ~tx_full_reg; // [R16] [R18] [R21]
         assign flag_rx[p] = rx_full;      // [R17] [R18] [R21]

         // read words, unimplemented bits stay zero
         assign rd_tx_ctrl[p] = {clk_src_reg, nine_tx_reg, tx_en_reg, sync_reg,
                                 2'h0, tsr_empty, tx_ninth_reg};           // [R5] [R19]
         assign rd_rx_ctrl[p] = {serial_port_enable_reg, nine_rx_reg, single_reg, cont_reg,
                                 1'b0, rx_framing_error_st, rx_overrun_error, rx_ninth};     // [R13] [R14] [R15] [R19]
         assign rd_rx_data[p] = rx_data;
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // read selection, other flag bits belong to other blocks and read zero
   logic [7:0] rd_byte;
   logic       mapped;
   always_comb begin
      rd_byte = 8'h00;
      mapped  = 1'b1;
      if (hit_tx_ctrl[0]) begin
         rd_byte = rd_tx_ctrl[0];
      end else if (hit_tx_ctrl[1]) begin
         rd_byte = rd_tx_ctrl[1];
      end else if (hit_rx_ctrl[0]) begin
         rd_byte = rd_rx_ctrl[0];
      end else if (hit_rx_ctrl[1]) begin
         rd_byte = rd_rx_ctrl[1];
      end else if (hit_rx_data[0]) begin
         rd_byte = rd_rx_data[0];
      end else if (hit_rx_data[1]) begin
         rd_byte = rd_rx_data[1];
      end else if (hit_flags_one) begin
         rd_byte = {6'h00, flag_tx[0], flag_rx[0]};                        // [R16] [R17]
      end else if (hit_flags_two) begin
         rd_byte = {6'h00, flag_tx[1], flag_rx[1]};                        // [R18]
      end else if (hit_irq_en) begin
         rd_byte = {4'h0, irq_en_reg};
      end else if (hit_tx_data[0] | hit_tx_data[1]) begin
         // transmit data is write only
         rd_byte = 8'h00;
      end else begin
         mapped = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // apb answer: ready one cycle after setup, data sampled at setup so a
   // buffer read and its consumption cannot drift apart
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= setup;
         pslverr <= setup & ~mapped;
         if (setup) begin
            prdata <= {24'h00_0000, rd_byte};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // interrupt enables and gated requests
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_en_reg <= `USC_IRQ_EN_RST;
         tx_irq     <= 2'h0;
         rx_irq     <= 2'h0;
      end else begin
         irq_en_reg <= irq_en_next;
         tx_irq     <= flag_tx & {irq_en_reg[`USC_IE_TX_TWO], irq_en_reg[`USC_IE_TX_ONE]}; // [R20]
         rx_irq     <= flag_rx & {irq_en_reg[`USC_IE_RX_TWO], irq_en_reg[`USC_IE_RX_ONE]}; // [R20]
      end
   end
endmodule

// *** verif/usc_top_assertions.sv ***
`timescale 1ns/1ps
// bus and link checks on the top ports
module usc_top_assertions (
   // clock and reset
   input wire logic                         pclk,
   input wire logic                         presetn,
   // apb
   input wire logic                         psel,
   input wire logic                         penable,
   input wire logic                         pready,
   input wire logic                         pslverr,
   // links
   input wire usc_pkg::usc_link_out_t [1:0] link_out
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////////////////////////
   // no second load in the three cycles after a load
   sequence s_quiet;
      !link_out[0].tx_load [*3];
   endsequence
   property p_setup_answer;
      psel && !penable |=> pready;
   endproperty
   property p_ready_pulse;
      pready |=> !pready;
   endproperty
   property p_err_ready;
      pslverr |-> pready && psel && penable;
   endproperty
   property p_master_sync;
      link_out[0].clk_master |-> link_out[0].sync_mode;
   endproperty
   property p_sync_priority;
      link_out[0].sync_mode && link_out[0].rx_run |-> !link_out[0].tx_run;
   endproperty
   property p_load_pins;
      link_out[0].tx_load |-> link_out[0].pin_enable;
   endproperty
   property p_load_width;
      link_out[0].tx_load && !link_out[0].nine_tx |-> link_out[0].tx_word[8] == 1'b0;
   endproperty
   property p_load_gap;
      link_out[0].tx_load |=> s_quiet;
   endproperty
   a_setup_answer: assert property (p_setup_answer) else $error("no answer after setup");
   a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");
   a_err_ready: assert property (p_err_ready) else $error("error outside access");
   a_master_sync: assert property (p_master_sync) else $error("master clock in async");
   a_sync_priority: assert property (p_sync_priority) else $error("tx runs over rx");
   a_load_pins: assert property (p_load_pins) else $error("load with port off");
   a_load_width: assert property (p_load_width) else $error("ninth bit in 8-bit");
   a_load_gap: assert property (p_load_gap) else $error("load while busy");
endmodule
bind usc_top usc_top_assertions u_chk (.pclk, .presetn, .psel, .penable, .pready, .pslverr, .link_out);

// *** verif/usc_link_model.sv ***
`timescale 1ns/1ps
// far-side datapath, busy SHIFT cycles per load
module usc_link_model #(parameter int SHIFT = 8) (
   // clock and reset
   input wire logic                   pclk,
   input wire logic                   presetn,
   // link
   input wire usc_pkg::usc_link_out_t lo,
   output usc_pkg::usc_link_in_t      li,
   // bench side
   input wire logic                   send,
   input wire logic [8:0]             word,
   input wire logic                   framing_error,
   output logic [8:0]                 got,
   output logic [7:0]                 loads
);
   int cnt; // cycles left to shift
   ////////////////////////////////////////////////////////////
   // capture the word and time its shifting
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 0;
         got <= 9'h000;
         loads <= 8'h00;
      end else if (lo.tx_load) begin
         cnt <= SHIFT;
         got <= lo.tx_word;
         loads <= loads + 8'h01;
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
      end
   end
   // done only while busy; data lines carry junk outside the strobe
   assign li.tsr_done = (cnt == 1);
   assign li.rx_valid = send;
   assign li.rx_word = send ? word : ~word;
   assign li.rx_framing_error = send ? framing_error : ~framing_error;
endmodule

// *** verif/usart_control_status_test.sv ***
`timescale 1ns/1ps
`include "usc_defs.svh"
// register level test of the serial port control block
module usart_control_status_test;
   logic                        pclk = 1'b0;
   logic                        presetn = 1'b0;
   logic                        psel = 1'b0;
   logic                        penable = 1'b0;
   logic                        pwrite = 1'b0;
   logic [11:0]                 paddr = 12'h000;
   logic [31:0]                 pwdata = 32'h00000000;
   logic [31:0]                 prdata;
   logic                        pready;
   logic                        pslverr;
   usc_pkg::usc_link_out_t [1:0] lout;
   wire usc_pkg::usc_link_in_t [1:0] lin;
   logic [1:0]                  tx_irq;
   logic [1:0]                  rx_irq;
   logic                        send = 1'b0;
   logic [8:0]                  word = 9'h000;
   logic                        framing_error = 1'b0;
   logic [8:0]                  got;
   logic [7:0]                  loads;
   logic [7:0]                  rd;
   logic                        er;
   int                          error_cnt = 0;
   int                          check_count = 0;
   usc_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
                .link_out(lout), .link_in(lin), .tx_irq, .rx_irq);
   usc_link_model m (.pclk, .presetn, .lo(lout[0]), .li(lin[0]), .send, .word, .framing_error, .got, .loads);
   // port two link stays idle
   assign lin[1] = '0;
   localparam logic [7:0] TXC = `USC_IDX_TX_CTRL_ONE, RXC = `USC_IDX_RX_CTRL_ONE, FL1 = `USC_IDX_FLAGS_ONE;
   localparam logic [7:0] TXD = `USC_IDX_TX_DATA_ONE, RXD = `USC_IDX_RX_DATA_ONE, IEN = `USC_IDX_IRQ_ENABLE;
   always #25 pclk = ~pclk;
   ////////////////////////////////////////////////////////////
   task test_done;
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task chk(input logic [8:0] g, input logic [8:0] e);
      check_count++;
      if (g !== e) begin
         error_cnt++;
         $display("BAD t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   // one apb transfer, held until pready
   task apb(input logic w, input logic [7:0] ix, input logic [7:0] wd);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {2'b00, ix, 2'b00};
      pwdata <= {24'h000000, wd};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         error_cnt++;
         test_done;
      end
      rd = prdata[7:0];
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [7:0] ix, input logic [7:0] wd);
      apb(1'b1, ix, wd);
   endtask
   task rc(input logic [7:0] ix, input logic [7:0] mk, input logic [7:0] e);
      apb(1'b0, ix, 8'h00);
      chk({1'b0, rd & mk}, {1'b0, e});
   endtask
   // one received character, one cycle
   task rcv(input logic [8:0] w, input logic f);
      @(posedge pclk);
      send <= 1'b1;
      word <= w;
      framing_error <= f;
      @(posedge pclk);
      send <= 1'b0;
   endtask
   task wl(input logic [7:0] n);
      int i;
      for (i = 0; i < 40 && loads !== n; i++) @(posedge pclk);
      if (loads !== n) begin
         error_cnt++;
         test_done;
      end
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      rc(TXC, 8'hff, 8'h02);
      rc(RXC, 8'hff, 8'h00);
      rc(FL1, 8'h03, 8'h02);
      rc(`USC_IDX_FLAGS_TWO, 8'h03, 8'h02);
      wr(FL1, 8'hfd);
      rc(FL1, 8'h03, 8'h02);
      wr(TXC, 8'hff);
      rc(TXC, 8'hff, 8'hf3);
      chk({7'h00, lout[0].sync_mode, lout[0].clk_master}, 9'h003);
      wr(RXC, 8'h90);
      rc(RXC, 8'hff, 8'h90);
      chk({6'h00, lout[0].pin_enable, lout[0].tx_run, lout[0].rx_run}, 9'h005);
      // async transmit, nine bits then eight
      wr(TXC, 8'h61);
      wr(RXC, 8'h80);
      wr(IEN, 8'h02);
      wr(TXD, 8'ha5);
      rc(FL1, 8'h02, 8'h02);
      rc(TXC, 8'hff, 8'h61);
      wl(8'h01);
      chk(got, 9'h1a5);
      wr(TXC, 8'h21);
      wr(TXD, 8'h3c);
      wl(8'h02);
      chk(got, 9'h03c);
      // async nine-bit receive with a framing error
      wr(RXC, 8'hd0);
      chk({7'h00, tx_irq}, 9'h001);
      wr(IEN, 8'h01);
      rcv(9'h15a, 1'b1);
      rc(FL1, 8'h01, 8'h01);
      chk({5'h00, tx_irq, rx_irq}, 9'h001);
      rc(RXC, 8'hff, 8'hd5);
      rc(RXD, 8'hff, 8'h5a);
      rc(RXC, 8'h04, 8'h00);
      rc(FL1, 8'h01, 8'h00);
      // overrun holds through a read, clears with continuous receive
      rcv(9'h011, 1'b0);
      rcv(9'h022, 1'b0);
      rc(RXC, 8'h02, 8'h02);
      rc(RXD, 8'hff, 8'h11);
      rc(RXC, 8'h02, 8'h02);
      wr(RXC, 8'hc0);
      rc(RXC, 8'h02, 8'h00);
      chk({8'h00, lout[0].rx_run}, 9'h000);
      wr(RXC, 8'h90);
      rcv(9'h1ee, 1'b0);
      rc(RXC, 8'h01, 8'h00);
      rc(RXD, 8'hff, 8'hee);
      // sync master single receive clears itself; slave ignores it
      wr(TXC, 8'h90);
      wr(RXC, 8'ha0);
      rc(RXC, 8'h20, 8'h20);
      chk({8'h00, lout[0].rx_run}, 9'h001);
      rcv(9'h033, 1'b0);
      rc(RXC, 8'h20, 8'h00);
      rc(RXD, 8'hff, 8'h33);
      wr(TXC, 8'h10);
      wr(RXC, 8'ha0);
      apb(1'b0, 8'h3f, 8'h00);
      chk({8'h00, er}, 9'h001);
      chk({8'h00, lout[0].rx_run}, 9'h000);
      test_done;
   end
endmodule
